// ===== verilog/pscs_defs.vh
// Purpose: constants for the power-on strap capture block
// Assumes: included by bare name from every design file of the block
// Notes: register offsets are indices; byte address is four times each
`ifndef PSCS_DEFS_VH
`define PSCS_DEFS_VH

// register indices and their Avalon byte addresses
`define PSCS_IDX_PCI_DIVISOR 8'h4c
`define PSCS_IDX_HOST_PLL 8'h5f
`define PSCS_IDX_CTRL 8'h60
`define PSCS_IDX_STATUS 8'h61
`define PSCS_ADDR_PCI_DIVISOR {`PSCS_IDX_PCI_DIVISOR, 2'b00}
`define PSCS_ADDR_HOST_PLL {`PSCS_IDX_HOST_PLL, 2'b00}
`define PSCS_ADDR_CTRL {`PSCS_IDX_CTRL, 2'b00}
`define PSCS_ADDR_STATUS {`PSCS_IDX_STATUS, 2'b00}
`define PSCS_ADDR_W 10

// strap lines taken into the block: memory data lines 26 down to 16
`define PSCS_LINE_LSB 16
`define PSCS_LINE_MSB 26
`define PSCS_LINE_W 11
// pci divisor register holds lines 20..16 in bits 4..0
`define PSCS_DIV_W 5
`define PSCS_DIV_SEL_BIT 1
// host pll register holds lines 26..21 in bits 5..0
`define PSCS_PLL_W 6
`define PSCS_PLL_LSB 3
`define PSCS_PLL_MSB 5
`define PSCS_PLL_CODE_W 3

// control register fields and reset value
`define PSCS_CTRL_PCI_EN_BIT 0
`define PSCS_CTRL_RESET 32'h00000001
// status register fields
`define PSCS_STAT_VALID_BIT 0
`define PSCS_STAT_DIV3_BIT 1
`define PSCS_STAT_PLL_LSB 4
`define PSCS_STAT_PLL_MSB 6

// edges after reset release before strap levels are trusted
`define PSCS_SETTLE_CYCLES 2'h3
// divider terminal counts for divide by two and divide by three
`define PSCS_DIV2_LAST 2'h1
`define PSCS_DIV3_LAST 2'h2

`endif

// ===== verilog/pscs_strap_sync.v
// Purpose: three-stage synchroniser for the strap pins
// Assumes: pins are quasi-static board straps with pull resistors
// Notes: a level counts once stages two and three agree
`include "pscs_defs.vh"

module pscs_strap_sync (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire [`PSCS_LINE_W-1:0] pins_in,
  output reg [`PSCS_LINE_W-1:0] level_out,
  output wire agree_out
);

  reg [`PSCS_LINE_W-1:0] stage1;
  reg [`PSCS_LINE_W-1:0] stage2;
  wire [`PSCS_LINE_W-1:0] bit_agree;

  // stage1 feeds stage2 only, so metastability never reaches a gate
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage1 <= {`PSCS_LINE_W{1'b0}};
      stage2 <= {`PSCS_LINE_W{1'b0}};
      level_out <= {`PSCS_LINE_W{1'b0}};
    end else begin
      stage1 <= pins_in;
      stage2 <= stage1;
      level_out <= stage2;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `PSCS_LINE_W; i = i + 1) begin : g_agree
      assign bit_agree[i] = ~(stage2[i] ^ level_out[i]);
    end
  endgenerate

  assign agree_out = &bit_agree;

endmodule

// ===== verilog/pscs_clk_div.v
// Purpose: derives the pci clock output from the system clock
// Assumes: select is stable whenever enable is high
// Notes: divide by two gives 50% duty, divide by three gives 1/3 high
`include "pscs_defs.vh"

module pscs_clk_div (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire enable_in,
  input wire div3_in,
  output reg clk_out
);

  reg [1:0] count;
  reg [1:0] next_count;
  wire [1:0] last;

  assign last = div3_in ? `PSCS_DIV3_LAST : `PSCS_DIV2_LAST;

  always @* begin
    if (!enable_in || count == last) begin
      next_count = 2'h0;
    end else begin
      next_count = count + 2'h1;
    end
  end

  // output is high only in the count-zero phase, low while disabled
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= 2'h0;
      clk_out <= 1'b0;
    end else begin
      count <= next_count;
      clk_out <= enable_in && (next_count == 2'h0);
    end
  end

endmodule

// ===== verilog/pscs_top.v
// Purpose: captures board strap levels and exposes them to software
// Assumes: Avalon-MM slave with waitrequest, byte addresses, 32-bit data
// Notes: straps are taken once after reset and frozen until next reset
//
// The Avalon-MM register port was left to the implementer.
`include "pscs_defs.vh"

// Notes on behaviour
// - pci divisor reg bits 4..0 show lines 20..16
// - bit 1 picks pci clock divide two or three
// - pci divisor reg defaults to captured strap levels
// - pll reg bits 5..0 show lines 26..21
// - pll bits 5..3 drive host synthesizer code
// - pll reg defaults to captured strap levels
// - strap positions 27 to 43 are ignored
module pscs_top (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire [`PSCS_LINE_MSB:`PSCS_LINE_LSB] memory_data_lines_in,
  input wire [`PSCS_ADDR_W-1:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  output wire pci_clk_out,
  output reg [`PSCS_PLL_CODE_W-1:0] host_pll_code_out,
  output reg strap_valid_out
);

  // capture sequence states
  localparam [1:0] ST_SETTLE = 2'h0;
  localparam [1:0] ST_AGREE = 2'h1;
  localparam [1:0] ST_HELD = 2'h2;

  // one-hot register selects
  localparam [3:0] SEL_NONE = 4'h0;
  localparam [3:0] SEL_DIV = 4'h1;
  localparam [3:0] SEL_PLL = 4'h2;
  localparam [3:0] SEL_CTRL = 4'h4;
  localparam [3:0] SEL_STAT = 4'h8;

  wire [`PSCS_LINE_W-1:0] strap_level;
  wire strap_agree;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [1:0] settle_count;
  reg [1:0] next_settle_count;
  reg capture_now;

  reg [`PSCS_DIV_W-1:0] pci_divisor;
  reg [`PSCS_PLL_W-1:0] host_pll;
  reg [31:0] ctrl;

  reg [3:0] rd_sel;
  reg [3:0] wr_sel;
  reg [31:0] next_readdata;
  reg next_waitrequest;
  wire bus_req;
  wire wr_commit;
  wire pci_enable;

  function [3:0] decode_sel;
    input [`PSCS_ADDR_W-1:0] addr;
    begin
      case (addr)
        `PSCS_ADDR_PCI_DIVISOR: decode_sel = SEL_DIV;
        `PSCS_ADDR_HOST_PLL: decode_sel = SEL_PLL;
        `PSCS_ADDR_CTRL: decode_sel = SEL_CTRL;
        `PSCS_ADDR_STATUS: decode_sel = SEL_STAT;
        default: decode_sel = SEL_NONE;
      endcase
    end
  endfunction

  // only lines 26..16 enter the block; 27..43 carry no function
  pscs_strap_sync i_pscs_strap_sync (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .pins_in(memory_data_lines_in),
    .level_out(strap_level),
    .agree_out(strap_agree)
  );

  // capture sequence: wait for the synchroniser to fill, then take
  // the first stable sample; a pin that never settles stalls the bus
  always @* begin
    next_state = state;
    next_settle_count = settle_count;
    capture_now = 1'b0;
    case (state)
      ST_SETTLE: begin
        next_settle_count = settle_count + 2'h1;
        if (next_settle_count == `PSCS_SETTLE_CYCLES) begin
          next_state = ST_AGREE;
        end
      end
      ST_AGREE: begin
        if (strap_agree) begin
          capture_now = 1'b1;
          next_state = ST_HELD;
        end
      end
      ST_HELD: begin
        next_state = ST_HELD;
      end
      default: begin
        next_state = ST_SETTLE;
        next_settle_count = 2'h0;
      end
    endcase
  end

  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_SETTLE;
      settle_count <= 2'h0;
    end else begin
      state <= next_state;
      settle_count <= next_settle_count;
    end
  end

  // strap registers load once; later pin activity is ignored
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pci_divisor <= {`PSCS_DIV_W{1'b0}};
      host_pll <= {`PSCS_PLL_W{1'b0}};
      host_pll_code_out <= {`PSCS_PLL_CODE_W{1'b0}};
      strap_valid_out <= 1'b0;
    end else if (capture_now) begin
      pci_divisor <= strap_level[`PSCS_DIV_W-1:0];
      host_pll <= strap_level[`PSCS_LINE_W-1:`PSCS_DIV_W];
      host_pll_code_out <=
        strap_level[`PSCS_LINE_W-1:`PSCS_LINE_W-`PSCS_PLL_CODE_W];
      strap_valid_out <= 1'b1;
    end
  end

  // the pci clock stays low until straps are known, so the divisor
  // never switches mid-cycle
  assign pci_enable = strap_valid_out && ctrl[`PSCS_CTRL_PCI_EN_BIT];

  pscs_clk_div i_pscs_clk_div (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .enable_in(pci_enable),
    .div3_in(pci_divisor[`PSCS_DIV_SEL_BIT]),
    .clk_out(pci_clk_out)
  );

  // bus slave: requests wait until capture is done, then one cycle of
  // waitrequest low completes each access
  assign bus_req = avs_read_in || avs_write_in;
  assign wr_commit = avs_write_in && !avs_waitrequest_out;

  always @* begin
    rd_sel = decode_sel(avs_address_in);
    wr_sel = decode_sel(avs_address_in);
    next_waitrequest = 1'b1;
    if (bus_req && avs_waitrequest_out && state == ST_HELD) begin
      next_waitrequest = 1'b0;
    end
    next_readdata = 32'h00000000;
    case (rd_sel)
      SEL_DIV: begin
        next_readdata[`PSCS_DIV_W-1:0] = pci_divisor;
      end
      SEL_PLL: begin
        next_readdata[`PSCS_PLL_W-1:0] = host_pll;
      end
      SEL_CTRL: begin
        next_readdata = ctrl;
      end
      SEL_STAT: begin
        next_readdata[`PSCS_STAT_VALID_BIT] = strap_valid_out;
        next_readdata[`PSCS_STAT_DIV3_BIT] =
          pci_divisor[`PSCS_DIV_SEL_BIT];
        next_readdata[`PSCS_STAT_PLL_MSB:`PSCS_STAT_PLL_LSB] =
          host_pll_code_out;
      end
      default: begin
        next_readdata = 32'h00000000;
      end
    endcase
    // read data only stand in the cycle that waitrequest is low
    if (!avs_read_in || next_waitrequest) begin
      next_readdata = 32'h00000000;
    end
  end

  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h00000000;
    end else begin
      avs_waitrequest_out <= next_waitrequest;
      avs_readdata_out <= next_readdata;
    end
  end

  // strap registers are read-only; only bit 0 of the control register is writable
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl <= `PSCS_CTRL_RESET;
    end else if (wr_commit && wr_sel == SEL_CTRL &&
                 avs_byteenable_in[0]) begin
      ctrl <= {31'h00000000, avs_writedata_in[`PSCS_CTRL_PCI_EN_BIT]};
    end
  end

endmodule

// ===== testbench/pscs_checker.sv
// Purpose: port assertions for the strap capture block
// Assumes: straps hold still from reset release until capture
// Notes: snap follows the pins until valid rises, then freezes
module pscs_checker (
  input wire sys_clk_in,
  input wire nrst_in,
  input wire [26:16] memory_data_lines_in,
  input wire [9:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  input wire pci_clk_out,
  input wire [2:0] host_pll_code_out,
  input wire strap_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [26:16] snap;
  reg en;
  wire acc = avs_read_in && !avs_waitrequest_out;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  // pci enable tracked so a stopped clock is not flagged
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en <= 1'b1;
    end else begin
      if (!strap_valid_out)
        snap <= memory_data_lines_in;
      if (avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
          && avs_address_in == 10'h180)
        en <= avs_writedata_in[0];
    end
  end
  AST_PCI_DIV_READ: assert property (
    acc && avs_address_in == 10'h130 |->
    avs_readdata_out == {27'h0, snap[20:16]}) else $error("bad div read");
  AST_PLL_READ: assert property (
    acc && avs_address_in == 10'h17c |->
    avs_readdata_out == {26'h0, snap[26:21]}) else $error("bad pll read");
  AST_PLL_CODE: assert property (
    strap_valid_out ##1 strap_valid_out |->
    host_pll_code_out == snap[26:24]) else $error("bad pll code");
  AST_VALID_HOLD: assert property (
    strap_valid_out |=> strap_valid_out) else $error("valid dropped");
  AST_WAIT_HOLD: assert property (
    !strap_valid_out |-> avs_waitrequest_out) else $error("early ack");
  AST_PCI_HIGH_ONE: assert property (
    $rose(pci_clk_out) |=> !pci_clk_out) else $error("pci high too long");
  AST_PCI_DIV3_LOW: assert property (
    $rose(pci_clk_out) && snap[17] |=> !pci_clk_out ##1 !pci_clk_out)
    else $error("div3 low too short");
  AST_PCI_DIV2_LOW: assert property (
    en && !snap[17] && $fell(pci_clk_out) |=> pci_clk_out || !en)
    else $error("div2 low too long");
endmodule

bind pscs_top pscs_checker i_pscs_checker (.sys_clk_in, .nrst_in,
  .memory_data_lines_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
  .avs_waitrequest_out, .pci_clk_out, .host_pll_code_out, .strap_valid_out);

// ===== testbench/pscs_strap_board.sv
// Purpose: board resistors on the strap lines
// Assumes: user bits model jumpers on the board
// Notes: reserved lines carry pull-ups, so they read high
module pscs_strap_board (
  input wire [3:0] user_in,
  output wire [26:16] lines_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // lines 26..24 and 17 are user straps, all others pulled up
  assign lines_out = {user_in[3:1], 6'h3f, user_in[0], 1'b1};
endmodule

// ===== testbench/pscs_top_tb_top.sv
// Purpose: self-checking bench for the strap capture block
// Assumes: one clock, Avalon master tasks below
// Notes: two resets with different straps cover both divisors
module pscs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 0, nrst_in = 0, rd = 0, wr = 0;
  logic [9:0] addr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] be = 0, straps = 4'ha;
  wire [31:0] rdata;
  wire wait_req, pci, valid;
  wire [2:0] code;
  wire [26:16] lines;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  pscs_strap_board i_pscs_strap_board (.user_in(straps), .lines_out(lines));
  pscs_top i_pscs_top (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .memory_data_lines_in(lines), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_req), .pci_clk_out(pci),
    .host_pll_code_out(code), .strap_valid_out(valid));
  initial forever #5 sys_clk_in = ~sys_clk_in;
  task close_out;
    $display("Checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // whole run is under two hundred cycles; this only cuts a hang
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [9:0] a, input logic [31:0] d,
           input logic [3:0] b, output logic [31:0] q);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    be <= b;
    rd <= !w;
    wr <= w;
    do @(posedge sys_clk_in); while (wait_req !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rd_chk(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(q, e);
  endtask
  task do_reset(input logic [3:0] s);
    straps <= s;
    nrst_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
  endtask
  task t_regs(input logic [3:0] s);
    rd_chk(10'h130, {27'h0, 3'b111, s[0], 1'b1});
    rd_chk(10'h17c, {26'h0, s[3:1], 3'b111});
    rd_chk(10'h184, {25'h0, s[3:1], 2'b00, s[0], 1'b1});
    chk({29'h0, code}, {29'h0, s[3:1]});
    rd_chk(10'h3fc, 32'h0);
  endtask
  task t_hold(input logic [3:0] s_new, input logic [3:0] s_old);
    logic [31:0] q;
    bus(1'b1, 10'h130, 32'h0, 4'hf, q);
    bus(1'b1, 10'h17c, 32'h0, 4'hf, q);
    straps <= s_new;
    repeat (8) @(posedge sys_clk_in);
    t_regs(s_old);
  endtask
  task t_pci(input logic div3);
    int n;
    logic [31:0] q;
    @(posedge pci);
    n = 0;
    do begin
      @(posedge sys_clk_in);
      #1 n++;
    end while (pci !== 1'b1);
    chk(n, div3 ? 32'h3 : 32'h2);
    bus(1'b1, 10'h180, 32'h0, 4'h0, q);
    rd_chk(10'h180, 32'h1);
    bus(1'b1, 10'h180, 32'h0, 4'h1, q);
    rd_chk(10'h180, 32'h0);
    repeat (3) @(posedge sys_clk_in);
    n = 0;
    repeat (6) begin
      @(negedge sys_clk_in);
      n += pci;
    end
    chk(n, 32'h0);
    bus(1'b1, 10'h180, 32'h1, 4'h1, q);
  endtask
  initial begin
    do_reset(4'ha);
    t_regs(4'ha);
    t_pci(1'b0);
    t_hold(4'h7, 4'ha);
    do_reset(4'h7);
    t_regs(4'h7);
    t_pci(1'b1);
    close_out();
  end
endmodule
